//--- src/pit_timer.sv
/*
 * prescaled interval timer with apb register slave and level interrupt.
 * assumes an apb master on clk; irq goes to the processor interrupt logic.
 */
`timescale 1ns/1ns
module pit_timer
    import pit_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt
    output logic irq
);
    logic rst_meta, rst_sync_n;
    pit_count_t timer_count, timer_period;
    pit_scale_t timer_prescale, scale_in;
    logic run, zero_sts, zero_en, scale_wr;
    logic tick, zero_evt, wr_en, rd_en, known;
    pit_apb_req_s req;

    // reset released through two flops, asserted at once
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // bus decode; slave answers in the first access cycle
    assign req = '{addr: paddr, write: pwrite, wdata: pwdata};
    assign pready = 1'b1;
    assign wr_en = psel && penable && req.write;
    assign rd_en = psel && penable && !req.write;
    always_comb begin
        case (req.addr)
            `PIT_OFS_COUNT, `PIT_OFS_PRESCALE, `PIT_OFS_PERIOD,
            `PIT_OFS_CTRL, `PIT_OFS_STATUS, `PIT_OFS_CLEAR,
            `PIT_OFS_ENABLE: known = 1'b1;
            default: known = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !known;
    assign scale_wr = wr_en && req.addr == `PIT_OFS_PRESCALE;
    // a prescale write reloads the cycle counter with the new value at
    // once; the register itself only takes it at the same edge
    assign scale_in = scale_wr ? req.wdata[7:0] : timer_prescale;

    // zero reached while the count decrements from one
    assign zero_evt = tick && timer_count == 16'h0001;

    pit_prescaler u_prescaler (
        .clk(clk),
        .rst_n(rst_sync_n),
        .run(run),
        .restart(scale_wr),
        .scale(scale_in),
        .tick(tick)
    );

    // control and setup registers
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            run <= 1'b0;
            timer_prescale <= `PIT_RST_SCALE;
            timer_period <= `PIT_RST_PERIOD;
            zero_en <= 1'b0;
        end else if (wr_en) begin
            case (req.addr)
                `PIT_OFS_CTRL: run <= req.wdata[`PIT_BIT_RUN];
                `PIT_OFS_PRESCALE: timer_prescale <= req.wdata[7:0];
                `PIT_OFS_PERIOD: timer_period <= req.wdata[15:0];
                `PIT_OFS_ENABLE: zero_en <= req.wdata[`PIT_BIT_ZERO];
                default: ;
            endcase
        end
    end

    // count register; software write beats a tick in the same cycle
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            timer_count <= `PIT_RST_COUNT;
        end else if (wr_en && req.addr == `PIT_OFS_COUNT) begin
            timer_count <= req.wdata[15:0];
        end else if (zero_evt) begin
            timer_count <= timer_period;
        end else if (tick && timer_count != 16'h0000) begin
            timer_count <= timer_count - 16'h0001;
        end
    end

    // sticky status; a new event wins over a clear in the same cycle
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            zero_sts <= 1'b0;
        end else if (zero_evt) begin
            zero_sts <= 1'b1;
        end else if (wr_en && req.addr == `PIT_OFS_CLEAR &&
                     req.wdata[`PIT_BIT_ZERO]) begin
            zero_sts <= 1'b0;
        end
    end

    // read data held in a flop; clear register reads as zero
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `PIT_OFS_COUNT: prdata <= {16'h0000, timer_count};
                `PIT_OFS_PRESCALE: prdata <= {24'h000000, timer_prescale};
                `PIT_OFS_PERIOD: prdata <= {16'h0000, timer_period};
                `PIT_OFS_CTRL: prdata <= {31'h0, run};
                `PIT_OFS_STATUS: prdata <= {31'h0, zero_sts};
                `PIT_OFS_ENABLE: prdata <= {31'h0, zero_en};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // level interrupt toward the processor
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            irq <= 1'b0;
        end else begin
            irq <= zero_sts && zero_en;
        end
    end

    // checks run on the core clock and stay quiet until the internal
    // reset copy has been released
    chk_count_decr: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        tick && timer_count > 16'h0001 && !wr_en
        |=> timer_count == $past(timer_count) - 16'h0001)
        else $error("count did not decrement on tick");
    chk_count_hold: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        !tick && !wr_en |=> $stable(timer_count))
        else $error("count moved without tick");
    chk_zero_reload: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        zero_evt && !wr_en |=> timer_count == $past(timer_period))
        else $error("count not reloaded from period");
    chk_zero_flag: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        zero_evt |=> zero_sts)
        else $error("zero event did not set status");
    chk_irq_level: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        zero_evt && zero_en && !wr_en |=> ##1 irq)
        else $error("interrupt not raised on zero");
    // a tick reloads the prescaler, so ticks only run back to back when
    // the prescale value is zero
    chk_tick_source: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        tick && timer_prescale != 8'h00 && !scale_wr |=> !tick)
        else $error("prescaler ticked on consecutive cycles");
    chk_scale_apply: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        scale_wr |=> timer_prescale == $past(req.wdata[7:0]))
        else $error("prescale write lost");
    chk_bus_error: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        psel && penable && pwrite && !known
        |=> $stable(timer_period) && $stable(timer_prescale) &&
            $stable(run) && $stable(zero_en))
        else $error("write to unmapped address changed a register");
    // read data is captured in the setup cycle, one cycle before access
    chk_status_read: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        rd_en && req.addr == `PIT_OFS_STATUS
        |-> prdata == {31'h0, $past(zero_sts)})
        else $error("status read wrong");
    chk_count_read: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        rd_en && req.addr == `PIT_OFS_COUNT
        |-> prdata == {16'h0000, $past(timer_count)})
        else $error("count read wrong");
    chk_period_read: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        rd_en && req.addr == `PIT_OFS_PERIOD
        |-> prdata == {16'h0000, $past(timer_period)})
        else $error("period read wrong");
    chk_unmapped_read: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        rd_en && !known |-> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_ctrl_write: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        wr_en && req.addr == `PIT_OFS_CTRL
        |=> run == $past(req.wdata[`PIT_BIT_RUN]))
        else $error("run bit write lost");
    // a zero event in the same cycle keeps the flag set
    chk_clear_status: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        wr_en && req.addr == `PIT_OFS_CLEAR &&
        req.wdata[`PIT_BIT_ZERO] && !zero_evt |=> !zero_sts)
        else $error("status clear lost");
    chk_irq_mask: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        !zero_en |=> !irq)
        else $error("interrupt raised while masked");
    chk_irq_drop: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        !zero_sts |=> !irq)
        else $error("interrupt raised without status");

    // main scenarios: reload, interrupt, clear, restart, refused access
    cov_reload: cover property (@(posedge clk) disable iff (!rst_sync_n)
        zero_evt);
    cov_irq: cover property (@(posedge clk) disable iff (!rst_sync_n)
        $rose(irq));
    cov_clear: cover property (@(posedge clk) disable iff (!rst_sync_n)
        $fell(zero_sts));
    cov_restart_run: cover property (@(posedge clk) disable iff (!rst_sync_n)
        scale_wr && run);
    cov_refused: cover property (@(posedge clk) disable iff (!rst_sync_n)
        pslverr);
endmodule // pit_timer

//--- src/pit_params.svh
/*
 * constants for the prescaled interval timer: register offsets, field
 * widths, reset values and control bit positions.
 * assumes inclusion by bare name from the timer package and modules.
 */
// Summary of operation
// - 16-bit count register decrements every n cycles
// - 8-bit prescale holds n minus one
// - count reaching zero raises timer interrupt
// - zero reloads count from 16-bit period
`ifndef PIT_PARAMS_SVH
`define PIT_PARAMS_SVH

`define PIT_OFS_COUNT 12'h000
`define PIT_OFS_PRESCALE 12'h004
`define PIT_OFS_PERIOD 12'h008
`define PIT_OFS_CTRL 12'h00c
`define PIT_OFS_STATUS 12'h010
`define PIT_OFS_CLEAR 12'h014
`define PIT_OFS_ENABLE 12'h018

`define PIT_COUNT_W 16
`define PIT_SCALE_W 8
`define PIT_RST_COUNT 16'h0000
`define PIT_RST_SCALE 8'h00
`define PIT_RST_PERIOD 16'h0000
`define PIT_BIT_RUN 0
`define PIT_BIT_ZERO 0

`endif

//--- src/pit_pkg.sv
/*
 * types shared by the prescaled interval timer files.
 * assumes pit_params.svh sits on the include path.
 */
`include "pit_params.svh"
package pit_pkg;
    typedef logic [`PIT_COUNT_W-1:0] pit_count_t;
    typedef logic [`PIT_SCALE_W-1:0] pit_scale_t;
    // apb request as seen by the slave
    typedef struct packed {
        logic [11:0] addr;
        logic write;
        logic [31:0] wdata;
    } pit_apb_req_s;
    typedef enum logic [1:0] {
        pit_idle,
        pit_access
    } pit_bus_e;
endpackage

//--- src/pit_prescaler.sv
/*
 * prescale cycle down-counter; one tick per scale+1 cycles.
 * assumes a synchronous reset copy and enable from the timer top.
 */
`timescale 1ns/1ns
module pit_prescaler
    import pit_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic run,
    input wire logic restart,
    input pit_scale_t scale,
    // output
    output logic tick
);
    pit_scale_t cnt;

    // expiry when the cycle counter is at zero while running
    assign tick = run && (cnt == '0);

    // reload on expiry gives scale+1 cycles per tick
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= `PIT_RST_SCALE;
        end else if (restart || !run) begin
            cnt <= scale;
        end else if (tick) begin
            cnt <= scale;
        end else begin
            cnt <= cnt - 8'h01;
        end
    end

    // tick spacing is exactly scale+1 cycles while untouched
    logic [8:0] gap;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap <= 9'h000;
        end else if (tick || restart || !run) begin
            gap <= 9'h000;
        end else begin
            gap <= gap + 9'h001;
        end
    end
    chk_tick_reload: assert property (
        @(posedge clk) disable iff (!rst_n)
        tick && !restart |=> cnt == $past(scale))
        else $error("prescaler not reloaded on expiry");
    chk_tick_gap: assert property (
        @(posedge clk) disable iff (!rst_n)
        tick && !restart |-> gap == {1'b0, scale})
        else $error("prescale tick spacing wrong");
endmodule // pit_prescaler

//--- verification/tb_top.sv
/*
 * self-checking bench for the prescaled interval timer: register reset
 * values and widths, bus errors, interrupt spacing, reload and masking.
 * assumes pit_params.svh on the include path and pit_pkg compiled first.
 */
`timescale 1ns/1ns
`include "pit_params.svh"
module tb_top
    import pit_pkg::*;
;
    logic clk;
    logic rst_n;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [31:0] rd;
    logic er;
    int n_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    int t0;
    int sc[3] = '{0, 3, 255};
    int pe[3] = '{9, 5, 2};
    logic [11:0] ofs[6] = '{`PIT_OFS_COUNT, `PIT_OFS_PRESCALE,
        `PIT_OFS_PERIOD, `PIT_OFS_CTRL, `PIT_OFS_STATUS, `PIT_OFS_ENABLE};

    pit_timer u_dut (
        .clk(clk),
        .rst_n(rst_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .irq(irq)
    );

    // free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // cycle count, also the hang guard: the longest case needs ~1050
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            n_errors++;
            final_report();
        end
    end

    task final_report;
        if (n_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; request held until pready is seen at an edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // sampled just after the edge so the registered line has settled
    task wait_irq(input logic lvl);
        do begin
            @(posedge clk);
            #1;
        end while (irq !== lvl);
    endtask

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        // every register except clear comes out of reset as zero
        foreach (ofs[i]) begin
            apb(1'b0, ofs[i], 32'h0);
            chk(rd, 32'h00000000);
        end
        // all ones written come back trimmed to the field width
        apb(1'b1, `PIT_OFS_COUNT, 32'hffffffff);
        apb(1'b0, `PIT_OFS_COUNT, 32'h0);
        chk(rd, 32'h0000ffff);
        apb(1'b1, `PIT_OFS_PRESCALE, 32'hffffffff);
        apb(1'b0, `PIT_OFS_PRESCALE, 32'h0);
        chk(rd, 32'h000000ff);
        apb(1'b1, `PIT_OFS_PERIOD, 32'hffffffff);
        apb(1'b0, `PIT_OFS_PERIOD, 32'h0);
        chk(rd, 32'h0000ffff);
        // unmapped slot answers with an error and reads zero
        apb(1'b0, 12'h01c, 32'h0);
        chk(rd, 32'h00000000);
        chk({31'h0, er}, 32'h00000001);
        // status ignores software writes
        apb(1'b1, `PIT_OFS_STATUS, 32'h1);
        apb(1'b0, `PIT_OFS_STATUS, 32'h0);
        chk(rd, 32'h00000000);
        chk({31'h0, er}, 32'h00000000);
        // spacing of events is period times (prescale + 1), edge values too
        apb(1'b1, `PIT_OFS_ENABLE, 32'h1);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, `PIT_OFS_CTRL, 32'h0);
            apb(1'b1, `PIT_OFS_CLEAR, 32'h1);
            apb(1'b1, `PIT_OFS_PRESCALE, 32'(sc[i]));
            apb(1'b1, `PIT_OFS_PERIOD, 32'(pe[i]));
            apb(1'b1, `PIT_OFS_COUNT, 32'(pe[i]));
            apb(1'b1, `PIT_OFS_CTRL, 32'h1);
            wait_irq(1'b1);
            t0 = cyc;
            apb(1'b1, `PIT_OFS_CLEAR, 32'h1);
            apb(1'b0, `PIT_OFS_STATUS, 32'h0);
            chk(rd, 32'h00000000);
            wait_irq(1'b1);
            chk(32'(cyc - t0), 32'(pe[i] * (sc[i] + 1)));
        end
        // slow case: counter already holds the period after the event
        apb(1'b0, `PIT_OFS_COUNT, 32'h0);
        chk(rd, 32'h00000002);
        // masked: status still latches but the line stays low
        apb(1'b1, `PIT_OFS_ENABLE, 32'h0);
        apb(1'b1, `PIT_OFS_CLEAR, 32'h1);
        repeat (600) @(posedge clk);
        chk({31'h0, irq}, 32'h00000000);
        apb(1'b0, `PIT_OFS_STATUS, 32'h0);
        chk(rd, 32'h00000001);
        apb(1'b1, `PIT_OFS_ENABLE, 32'h1);
        repeat (2) @(posedge clk);
        #1;
        chk({31'h0, irq}, 32'h00000001);
        // prescale rewritten while running takes effect at once; t0 is read
        // before the access edge counts and irq trails status by one edge
        apb(1'b1, `PIT_OFS_CTRL, 32'h0);
        apb(1'b1, `PIT_OFS_CLEAR, 32'h1);
        apb(1'b1, `PIT_OFS_PRESCALE, 32'h0000000f);
        apb(1'b1, `PIT_OFS_COUNT, 32'h3);
        apb(1'b1, `PIT_OFS_CTRL, 32'h1);
        apb(1'b1, `PIT_OFS_PRESCALE, 32'h1);
        t0 = cyc;
        wait_irq(1'b1);
        chk(32'(cyc - t0), 32'(3 * (1 + 1) + 2));
        final_report();
    end
endmodule // tb_top
